//--- inc/irq_defs.svh
// constants of the board interrupt block: offsets, bits, levels, vectors
// assumes inclusion by bare name from any file that needs them
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ------------------------------------------------------------
`define IRQ_OFF_STATUS   8'h00
`define IRQ_OFF_MASK     8'h04
`define IRQ_OFF_LEVELS   8'h08
`define IRQ_OFF_LAST_ACK 8'h0c

// ------------------------------------------------------------
// status and mask layout: bits 6..0 on-board, 13..7 bus levels 7..1
// ------------------------------------------------------------
`define IRQ_EVT_W        14
`define IRQ_BUS_LSB      7
`define IRQ_STATUS_RST   14'h0000
`define IRQ_MASK_RST     14'h0000

// ------------------------------------------------------------
// fixed levels and autovector numbers of on-board sources
// ------------------------------------------------------------
`define IRQ_LVL_ABORT    3'h7
`define IRQ_LVL_CLOCK    3'h6
`define IRQ_LVL_PARTIM   3'h5
`define IRQ_LVL_TERM     3'h4
`define IRQ_LVL_REMOTE   3'h3
`define IRQ_LVL_HOST     3'h2
`define IRQ_VEC_ABORT    8'h1f
`define IRQ_VEC_CLOCK    8'h1e
`define IRQ_VEC_PARTIM   8'h1d
`define IRQ_VEC_TERM     8'h1c
`define IRQ_VEC_REMOTE   8'h1b
`define IRQ_VEC_HOST     8'h1a
`define IRQ_VEC_NONE     8'h00

// ------------------------------------------------------------
// axi responses
// ------------------------------------------------------------
`define IRQ_RESP_OKAY    2'h0
`define IRQ_RESP_SLVERR  2'h2

`endif

//--- inc/irq_pkg.sv
// types shared by the board interrupt block
// assumes nothing of its surroundings
package irq_pkg;

  // on-board request lines, active high, one bit per source
  typedef struct packed {
    logic abort;
    logic clock;
    logic par_port;
    logic par_timer;
    logic term;
    logic remote;
    logic host;
  } onboard_req_t;

  // answer to one processor acknowledge cycle
  typedef struct packed {
    logic       autovector;
    logic       pass_bus;
    logic [2:0] level;
    logic [7:0] vector;
  } ack_t;

endpackage : irq_pkg

//--- rtl/board_interrupt_autovector.sv
// board interrupt collector: priority level and autovector acknowledge
// assumes an axi4-lite master on clk_sys and an acknowledge strobe
// from processor glue logic on the same clock
//
// Contract
// - Any on-board source is acknowledged by a forced autovector.
// - The abort switch requests level 7 and answers vector 31.
// - The real-time clock requests level 6 and answers vector 30.
// - The parallel/timer unit requests level 5 and answers vector 29.
// - The terminal serial adapter requests level 4, vector 28.
// - Remote serial is level 3 vector 27; host serial level 2 vector 26.
// - All seven backplane request lines reach their own level.
// - A backplane line whose jumper is off never reaches the processor.
// - Both the port and the timer request of the unit use level 5.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"

module board_interrupt_autovector (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // on-board request pins, active high
  input  wire irq_pkg::onboard_req_t onboard_pin,
  // backplane request pins, active low, bit i is level i+1
  input  wire logic [6:0]           bus_irq_n,
  input  wire logic [6:0]           bus_jumper_en,
  // processor priority inputs and acknowledge
  output logic      [2:0]           ipl_n,
  input  wire logic                 iack_strobe,
  input  wire logic [2:0]           iack_level,
  output irq_pkg::ack_t             ack,
  output logic                      ack_done,
  // axi4-lite slave
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // interrupt to software
  output logic                      irq
);
  import irq_pkg::*;

  // ----------------------------------------------------------
  // functions
  // ----------------------------------------------------------
  function automatic logic [2:0] top_level(input logic [7:1] lv);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (lv[i]) r = 3'(i);
    end
    return r;
  endfunction : top_level

  // autovector and presence of an on-board source at one level
  function automatic logic [7:0] board_vec(input onboard_req_t s,
                                           input logic [2:0] l);
    logic [7:0] v;
    v = `IRQ_VEC_NONE;
    case (l)
      `IRQ_LVL_ABORT:  if (s.abort) v = `IRQ_VEC_ABORT;
      `IRQ_LVL_CLOCK:  if (s.clock) v = `IRQ_VEC_CLOCK;
      `IRQ_LVL_PARTIM: if (s.par_port | s.par_timer) v = `IRQ_VEC_PARTIM;
      `IRQ_LVL_TERM:   if (s.term) v = `IRQ_VEC_TERM;
      `IRQ_LVL_REMOTE: if (s.remote) v = `IRQ_VEC_REMOTE;
      `IRQ_LVL_HOST:   if (s.host) v = `IRQ_VEC_HOST;
      default:         v = `IRQ_VEC_NONE;
    endcase
    return v;
  endfunction : board_vec

  function automatic logic [13:0] lanes(input logic [31:0] d,
                                        input logic [3:0] s);
    return d[13:0] & {{6{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  // ----------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------
  onboard_req_t src;
  logic [6:0]   bus_n_s;
  logic [6:0]   jumper_s;

  pin_sync #(
    .WIDTH     (21),
    .RESET_VAL ({7'h00, 7'h7f, 7'h00})
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin     ({onboard_pin, bus_irq_n, bus_jumper_en}),
    .level   ({src, bus_n_s, jumper_s})
  );

  // ----------------------------------------------------------
  // level merge and acknowledge
  // ----------------------------------------------------------
  logic [6:0]  bus_act;
  logic [7:1]  lvl;
  logic [7:0]  hit_vec;
  logic [2:0]  next_ipl_n;
  ack_t        next_ack;
  logic        next_ack_done;

  // jumpers are static, so the filtered level is used as it stands
  always_comb begin
    bus_act = ~bus_n_s & jumper_s;
    lvl[7] = src.abort | bus_act[6];
    lvl[6] = src.clock | bus_act[5];
    lvl[5] = src.par_port | src.par_timer | bus_act[4];
    lvl[4] = src.term | bus_act[3];
    lvl[3] = src.remote | bus_act[2];
    lvl[2] = src.host | bus_act[1];
    lvl[1] = bus_act[0];
    next_ipl_n = ~top_level(lvl);
    hit_vec = board_vec(src, iack_level);
    next_ack = ack;
    next_ack_done = 1'b0;
    // on-board wins its level; otherwise the backplane supplies the vector
    if (iack_strobe) begin
      next_ack.autovector = (hit_vec != `IRQ_VEC_NONE);
      next_ack.pass_bus   = (hit_vec == `IRQ_VEC_NONE);
      next_ack.level      = iack_level;
      next_ack.vector     = hit_vec;
      next_ack_done       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ipl_n    <= 3'h7;
      ack      <= '0;
      ack_done <= 1'b0;
    end else begin
      ipl_n    <= next_ipl_n;
      ack      <= next_ack;
      ack_done <= next_ack_done;
    end
  end

  // ----------------------------------------------------------
  // events, status and register slave
  // ----------------------------------------------------------
  logic [13:0] status, next_status, mask, next_mask;
  logic [13:0] prev_req, req_now, events;
  logic        aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0]  wa, next_wa;
  logic [31:0] wd, next_wd;
  logic [3:0]  ws, next_ws;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid, next_irq;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    req_now = {bus_act, src};
    events  = req_now & ~prev_req;
    next_aw_got = aw_got | (awvalid & awready);
    next_w_got  = w_got | (wvalid & wready);
    next_wa = (awvalid & awready) ? awaddr : wa;
    next_wd = (wvalid & wready) ? wdata : wd;
    next_ws = (wvalid & wready) ? wstrb : ws;
    next_status = status;
    next_mask   = mask;
    next_bvalid = bvalid & ~bready;
    next_bresp  = bresp;
    // write commits once address and data are both in
    if (next_aw_got && next_w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `IRQ_RESP_OKAY;
      case (next_wa)
        `IRQ_OFF_STATUS:   next_status = status & ~lanes(next_wd, next_ws);
        `IRQ_OFF_MASK:     next_mask = (mask & ~lanes(32'hffffffff, next_ws))
                                       | lanes(next_wd, next_ws);
        `IRQ_OFF_LEVELS:   next_bresp = `IRQ_RESP_OKAY;
        `IRQ_OFF_LAST_ACK: next_bresp = `IRQ_RESP_OKAY;
        default:           next_bresp = `IRQ_RESP_SLVERR;
      endcase
    end
    // set wins over a clear in the same cycle
    next_status = next_status | events;
    next_irq = |(next_status & next_mask);
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready  = ~next_w_got & ~next_bvalid;
    next_rvalid  = rvalid & ~rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `IRQ_RESP_OKAY;
      case (araddr)
        `IRQ_OFF_STATUS:   next_rdata = {18'h0, status};
        `IRQ_OFF_MASK:     next_rdata = {18'h0, mask};
        `IRQ_OFF_LEVELS:   next_rdata = {21'h0, ipl_n, lvl, 1'b0};
        `IRQ_OFF_LAST_ACK: next_rdata = {19'h0, ack};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `IRQ_RESP_SLVERR;
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status   <= `IRQ_STATUS_RST;
      mask     <= `IRQ_MASK_RST;
      prev_req <= 14'h0;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      wa       <= 8'h0;
      wd       <= 32'h0;
      ws       <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= 2'h0;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rdata    <= 32'h0;
      rresp    <= 2'h0;
      irq      <= 1'b0;
    end else begin
      status   <= next_status;
      mask     <= next_mask;
      prev_req <= req_now;
      aw_got   <= next_aw_got;
      w_got    <= next_w_got;
      wa       <= next_wa;
      wd       <= next_wd;
      ws       <= next_ws;
      awready  <= next_awready;
      wready   <= next_wready;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      arready  <= next_arready;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      irq      <= next_irq;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  board_autovec_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    iack_strobe && (board_vec(src, iack_level) != `IRQ_VEC_NONE)
    |=> ack_done && ack.autovector && !ack.pass_bus)
    else $error("on-board acknowledge not autovectored");

  abort_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    src.abort |=> ipl_n == 3'h0)
    else $error("abort not presented at level 7");

  abort_vector_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    iack_strobe && iack_level == 3'h7 && src.abort
    |=> ack.vector == 8'h1f)
    else $error("abort vector wrong");

  clock_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    src.clock && lvl[7] == 1'b0 |=> ipl_n == 3'h1)
    else $error("clock not presented at level 6");

  partim_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (src.par_port || src.par_timer) && lvl[7:6] == 2'h0
    |=> ipl_n == 3'h2)
    else $error("parallel/timer not presented at level 5");

  serial_vectors_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    iack_strobe && ((iack_level == 3'h3 && src.remote)
                    || (iack_level == 3'h2 && src.host))
    |=> ack.vector == (($past(iack_level) == 3'h3) ? 8'h1b : 8'h1a))
    else $error("serial vectors wrong");

  term_vector_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    iack_strobe && iack_level == 3'h4 && src.term
    |=> ack.vector == 8'h1c && ack.level == 3'h4)
    else $error("terminal vector wrong");

  bus_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !bus_n_s[0] && jumper_s[0] |=> ipl_n != 3'h7)
    else $error("enabled bus level 1 lost");

  bus_blocked_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    jumper_s == 7'h0 && src == '0 |=> ipl_n == 3'h7)
    else $error("disabled bus line reached processor");

  highest_wins_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    lvl[4] && lvl[7:5] == 3'h0 |=> ipl_n == 3'h3 [*1])
    else $error("level 4 not encoded");

endmodule : board_interrupt_autovector

`default_nettype wire

//--- rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for a group of pins
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // pins in, filtered level out
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // stage1 feeds stage2 only; a bit moves once stages 2 and 3 agree
  always_comb begin
    next_level = (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule : pin_sync

`default_nettype wire

//--- verif/cpu_core_model.sv
// processor side of the interrupt block: runs one acknowledge per go
// assumes go is a one-cycle pulse, lag is stable while waiting
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // bench control
  input  wire logic       go,
  input  wire logic [3:0] lag,
  // priority in, acknowledge out
  input  wire logic [2:0] ipl_n,
  output logic            iack_strobe,
  output logic [2:0]      iack_level
);
  // ----------------------------------------
  // acknowledge sequencer
  // ----------------------------------------
  logic       armed;
  logic [3:0] wait_cnt;

  // level is scrambled between strobes so no stale value passes as valid
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed       <= 1'b0;
      wait_cnt    <= 4'h0;
      iack_strobe <= 1'b0;
      iack_level  <= 3'h0;
    end else begin
      iack_strobe <= 1'b0;
      iack_level  <= iack_level ^ 3'h5;
      if (go) begin
        armed    <= 1'b1;
        wait_cnt <= lag;
      end else if (armed && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (armed) begin
        armed       <= 1'b0;
        iack_strobe <= 1'b1;
        iack_level  <= ~ipl_n;
      end
    end
  end
endmodule : cpu_core_model

`default_nettype wire

//--- verif/testbench.sv
// self-checking bench of the board interrupt block
// assumes the package, the design and cpu_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import irq_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic         clk_sys   = 1'b0;
  logic         reset     = 1'b1;
  onboard_req_t pins      = '0;
  logic [6:0]   bus_irq_n = 7'h7f;
  logic [6:0]   jumper    = 7'h7f;
  logic         go        = 1'b0;
  logic [3:0]   lag       = 4'h0;
  logic [7:0]   awaddr    = 8'h00;
  logic [7:0]   araddr    = 8'h00;
  logic [31:0]  wdata     = 32'h0;
  logic [3:0]   wstrb     = 4'hf;
  logic         awvalid   = 1'b0;
  logic         wvalid    = 1'b0;
  logic         bready    = 1'b0;
  logic         arvalid   = 1'b0;
  logic         rready    = 1'b0;
  logic [2:0]   ipl_n, iack_level;
  logic         iack_strobe, ack_done, irq;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, resp;
  logic [31:0]  rdata, rd;
  ack_t         ack;
  ack_t         exp_q[$];
  int           miscompares = 0;
  int           n_tests     = 0;
  // level of each on-board request bit, host first
  localparam logic [2:0] LV [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7};

  always #20 clk_sys = ~clk_sys;

  board_interrupt_autovector DUT (
    .clk_sys, .reset, .onboard_pin(pins), .bus_irq_n,
    .bus_jumper_en(jumper), .ipl_n, .iack_strobe, .iack_level, .ack,
    .ack_done, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .irq
  );

  cpu_core_model cpu (
    .clk_sys, .reset, .go, .lag, .ipl_n, .iack_strobe, .iack_level
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic give_up();
    miscompares++;
    finish_test();
  endtask : give_up

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  // pins pass a synchroniser, so the level is awaited, never timed
  task automatic wait_ipl(input logic [2:0] e);
    int n;
    for (n = 0; n < 30 && ipl_n !== e; n++) @(posedge clk_sys);
    chk(32'(ipl_n), 32'(e));
    if (ipl_n !== e) give_up();
  endtask : wait_ipl

  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 20 && irq !== v; n++) @(posedge clk_sys);
    chk(32'(irq), 32'(v));
    if (irq !== v) give_up();
  endtask : wait_irq

  // one acknowledge with a random processor delay
  task automatic ack_now();
    int n;
    @(posedge clk_sys);
    go  <= 1'b1;
    lag <= 4'($urandom_range(0, 5));
    @(posedge clk_sys);
    go <= 1'b0;
    for (n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge clk_sys);
    if (exp_q.size() != 0) give_up();
  endtask : ack_now

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 40) give_up();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) give_up();
  endtask : axi_rd

  // each acknowledge result is matched against the oldest note
  always @(posedge clk_sys) begin
    if (ack_done === 1'b1) begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(32'(ack), 32'(exp_q.pop_front()));
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int i, k;
    logic [6:0] p, b, j;
    logic [2:0] best;
    void'($urandom(32'he04fd91b));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // every on-board source alone
    for (i = 0; i < 7; i++) begin
      pins <= onboard_req_t'(7'h01 << i);
      wait_ipl(3'h7 - LV[i]);
      exp_q.push_back({1'b1, 1'b0, LV[i], 8'h18 + 8'(LV[i])});
      ack_now();
      pins <= '0;
      wait_ipl(3'h7);
    end
    $display("test onboard done");
    // every backplane level alone
    for (i = 0; i < 7; i++) begin
      bus_irq_n <= ~(7'h01 << i);
      wait_ipl(3'(6 - i));
      exp_q.push_back({1'b0, 1'b1, 3'(i + 1), 8'h00});
      ack_now();
      bus_irq_n <= 7'h7f;
      wait_ipl(3'h7);
    end
    $display("test backplane done");
    // all lines asserted but every jumper off
    jumper    <= 7'h00;
    bus_irq_n <= 7'h00;
    repeat (12) @(posedge clk_sys);
    chk(32'(ipl_n), 32'h7);
    // random mixes: the highest enabled level wins
    for (i = 0; i < 12; i++) begin
      p = 7'($urandom);
      b = 7'($urandom);
      j = 7'($urandom);
      pins      <= onboard_req_t'(p);
      bus_irq_n <= b;
      jumper    <= j;
      best = 3'h0;
      for (k = 0; k < 7; k++) begin
        if (p[k] && LV[k] > best) best = LV[k];
        if (!b[k] && j[k] && 3'(k + 1) > best) best = 3'(k + 1);
      end
      repeat (8) @(posedge clk_sys);
      wait_ipl(~best);
    end
    pins      <= '0;
    bus_irq_n <= 7'h7f;
    jumper    <= 7'h7f;
    wait_ipl(3'h7);
    $display("test priority done");
    // status, mask and interrupt output
    axi_wr(8'h00, 32'h3fff, resp);
    chk(32'(resp), 32'h0);
    axi_rd(8'h04, rd, resp);
    chk(rd, 32'h0);
    // last acknowledge was bus level 7: passed on, no autovector
    axi_rd(8'h0c, rd, resp);
    chk(rd, 32'h0f00);
    pins <= onboard_req_t'(7'h40);
    wait_ipl(3'h0);
    axi_rd(8'h00, rd, resp);
    chk(rd, 32'h40);
    // abort alone: merged level 7 set, priority inputs all low
    axi_rd(8'h08, rd, resp);
    chk(rd, 32'h80);
    chk(32'(irq), 32'h0);
    axi_wr(8'h04, 32'h40, resp);
    wait_irq(1'b1);
    pins <= '0;
    wait_ipl(3'h7);
    axi_wr(8'h00, 32'h40, resp);
    wait_irq(1'b0);
    axi_rd(8'h00, rd, resp);
    chk(rd, 32'h0);
    // only byte lane 0 of the mask takes the write
    wstrb <= 4'h1;
    axi_wr(8'h04, 32'h3fff, resp);
    wstrb <= 4'hf;
    axi_rd(8'h04, rd, resp);
    chk(rd, 32'hff);
    $display("test registers done");
    // unmapped place answers with an error
    axi_rd(8'h10, rd, resp);
    chk(rd, 32'h0);
    chk(32'(resp), 32'h2);
    axi_wr(8'h10, 32'h1, resp);
    chk(32'(resp), 32'h2);
    $display("test unmapped done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
